// ### hdl/ldm_display_ctrl.sv
// multiplexed common-cathode display controller core
// assumes the host word is already deserialised into a parallel register access
`timescale 1ns/1ns

module ldm_display_ctrl
    import ldm_pkg::*;
#(
    parameter int BLINK_SLOW_CYC = ldm_pkg::BLINK_SLOW_HALF,
    parameter int BLINK_FAST_CYC = ldm_pkg::BLINK_FAST_HALF
)
(
    input wire logic clock,
    input wire logic rst_n,
    input wire logic multiplex_clock_in,
    output logic multiplex_clock_buffered,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    output logic [ldm_pkg::NUM_DIGITS-1:0] cathode_drive_outputs,
    output logic [ldm_pkg::SEG_W-1:0] segment_drive,
    input wire logic [ldm_pkg::GPIO_W-1:0] gpio_in,
    output logic [ldm_pkg::GPIO_W-1:0] gpio_out,
    output logic [ldm_pkg::GPIO_W-1:0] gpio_oe
);
    import ldm_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [2:0] osc_sync_q;
    logic osc_lvl_q;
    logic osc_tick;
    logic [GPIO_W-1:0] gp_s0_q, gp_s1_q, gp_s2_q, gp_lvl_q;
    logic [GPIO_W-1:0] gp_agree;
    logic [7:0] decode_q;
    logic [3:0] global_q;
    logic [2:0] scan_q;
    logic [7:0] cfg_q;
    logic [7:0] slot_q;
    logic [GPIO_W-1:0] gdata_q;
    logic [GPIO_W-1:0] pcfg_q;
    logic [7:0] inten_q [NUM_DIGITS];
    logic [7:0] plane0_q [PLANE_DEPTH];
    logic [7:0] plane1_q [PLANE_DEPTH];
    logic cfg_wr;
    logic [22:0] blink_cnt_q;
    logic [22:0] blink_top;
    logic phase_q;
    logic [5:0] sub_q;
    logic [3:0] step_q;
    logic [2:0] digit_q;
    logic sub_last;
    logic digit_adv;
    logic [7:0] rd_mux;
    logic [7:0] rdata_q;
    logic rvalid_q;
    logic [NUM_DIGITS-1:0] cath_q, cath_d;
    logic [SEG_W-1:0] seg_q, seg_d;
    logic [GPIO_W-1:0] gp_oe_q, gp_out_q;
    logic [GPIO_W-1:0] gp_rd;
    logic plane_sel;
    logic [7:0] lo_byte, hi_byte;
    logic [3:0] int_lo, int_hi;
    logic on_lo, on_hi;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic pwm_on(input logic [3:0] lvl, input logic [3:0] step);
        logic [4:0] n;
        n = {1'b0, lvl} + 5'h01;
        if (n > PWM_MAX_ON)
        begin
            n = PWM_MAX_ON; // last step always blank
        end
        return {1'b0, step} < n;
    endfunction

    function automatic logic [7:0] seven_seg(input logic [7:0] b, input logic dec);
        return dec ? {b[7], HEX_FONT[b[3:0]]} : b;
    endfunction

    function automatic logic [15:0] ascii_glyph(input logic [6:0] code);
        logic [6:0] idx;
        idx = 7'h00;
        if (code < HEX_CHARS)
        begin
            return ASCII_FONT[code];
        end
        if (code < ASCII_LO)
        begin
            return 16'h0000;
        end
        idx = code - ASCII_OFS;
        return ASCII_FONT[idx];
    endfunction

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    // sampled at 50 MHz, so multiplex clocks up to 8 MHz are seen reliably
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            osc_sync_q <= 3'h0;
            osc_lvl_q <= 1'b0;
        end
        else
        begin
            osc_sync_q <= {osc_sync_q[1:0], multiplex_clock_in};
            if (osc_sync_q[1] == osc_sync_q[2])
            begin
                osc_lvl_q <= osc_sync_q[2];
            end
        end
    end

    assign osc_tick = (osc_sync_q[1] == osc_sync_q[2]) && osc_sync_q[2] && !osc_lvl_q;

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gp_s0_q <= '0;
            gp_s1_q <= '0;
            gp_s2_q <= '0;
            gp_lvl_q <= '0;
        end
        else
        begin
            gp_s0_q <= gpio_in;
            gp_s1_q <= gp_s0_q;
            gp_s2_q <= gp_s1_q;
            gp_lvl_q <= (gp_agree & gp_s2_q) | (~gp_agree & gp_lvl_q);
        end
    end

    assign gp_agree = ~(gp_s1_q ^ gp_s2_q);

    // ------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------
    assign cfg_wr = reg_wr_en && (reg_addr == ADDR_CFG);

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            decode_q <= RST_BYTE;
            global_q <= RST_BYTE[3:0];
            scan_q <= RST_BYTE[2:0];
            cfg_q <= RST_BYTE;
            slot_q <= RST_BYTE;
            gdata_q <= RST_BYTE[4:0];
            pcfg_q <= RST_PORT_CFG;
            for (int i = 0; i < NUM_DIGITS; i++)
            begin
                inten_q[i] <= RST_BYTE;
            end
        end
        else if (reg_wr_en)
        begin
            case (reg_addr)
                ADDR_DECODE: decode_q <= reg_wdata;
                ADDR_GLOBAL: global_q <= reg_wdata[3:0];
                ADDR_SCAN: scan_q <= reg_wdata[2:0];
                ADDR_CFG: cfg_q <= reg_wdata & CFG_STORED_MASK;
                ADDR_GPIO_DATA: gdata_q <= reg_wdata[4:0];
                ADDR_PORT_CFG: pcfg_q <= reg_wdata[4:0];
                ADDR_SLOT: slot_q <= reg_wdata;
                default:
                begin
                    if (reg_addr[6:3] == ADDR_INTEN[6:3])
                    begin
                        inten_q[reg_addr[2:0]] <= reg_wdata;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // digit planes
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < PLANE_DEPTH; i++)
            begin
                plane0_q[i] <= RST_BYTE;
                plane1_q[i] <= RST_BYTE;
            end
        end
        else if (cfg_wr && reg_wdata[CFG_CLR])
        begin
            for (int i = 0; i < PLANE_DEPTH; i++)
            begin
                plane0_q[i] <= RST_BYTE;
                plane1_q[i] <= RST_BYTE;
            end
        end
        else if (reg_wr_en)
        begin
            if (reg_addr[6:4] == ADDR_PLANE0[6:4] || reg_addr[6:4] == ADDR_BOTH[6:4])
            begin
                plane0_q[reg_addr[3:0]] <= reg_wdata;
            end
            if (reg_addr[6:4] == ADDR_PLANE1[6:4] || reg_addr[6:4] == ADDR_BOTH[6:4])
            begin
                plane1_q[reg_addr[3:0]] <= reg_wdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // blink timing
    // ------------------------------------------------------------------
    assign blink_top = cfg_q[CFG_RATE] ? 23'(BLINK_FAST_CYC - 1) : 23'(BLINK_SLOW_CYC - 1);

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            blink_cnt_q <= 23'h0;
            phase_q <= 1'b0;
        end
        else if (cfg_wr && reg_wdata[CFG_BRST])
        begin
            blink_cnt_q <= 23'h0;
            phase_q <= 1'b0;
        end
        else if (osc_tick)
        begin
            // >= covers a switch from slow to fast mid-period
            if (blink_cnt_q >= blink_top)
            begin
                blink_cnt_q <= 23'h0;
                phase_q <= ~phase_q;
            end
            else
            begin
                blink_cnt_q <= blink_cnt_q + 23'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // scan and pwm timing
    // ------------------------------------------------------------------
    assign sub_last = (sub_q == 6'(STEP_OSC_CYCLES - 1));
    assign digit_adv = osc_tick && sub_last && (step_q == 4'(PWM_STEPS - 1));

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sub_q <= 6'h0;
            step_q <= 4'h0;
            digit_q <= 3'h0;
        end
        else if (osc_tick)
        begin
            sub_q <= sub_last ? 6'h0 : sub_q + 6'h1;
            if (sub_last)
            begin
                step_q <= step_q + 4'h1;
            end
            if (digit_adv)
            begin
                // a lowered limit below the current digit wraps at once
                digit_q <= (digit_q >= scan_q) ? 3'h0 : digit_q + 3'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // segment and cathode generation
    // ------------------------------------------------------------------
    always_comb
    begin
        plane_sel = cfg_q[CFG_BLINK] & phase_q;
        lo_byte = plane_sel ? plane1_q[{1'b0, digit_q}] : plane0_q[{1'b0, digit_q}];
        hi_byte = plane_sel ? plane1_q[{1'b1, digit_q}] : plane0_q[{1'b1, digit_q}];
        if (cfg_q[CFG_IMODE])
        begin
            int_lo = digit_q[0] ? inten_q[{1'b0, digit_q[2:1]}][7:4]
                : inten_q[{1'b0, digit_q[2:1]}][3:0];
            int_hi = digit_q[0] ? inten_q[{1'b1, digit_q[2:1]}][7:4]
                : inten_q[{1'b1, digit_q[2:1]}][3:0];
        end
        else
        begin
            int_lo = global_q;
            int_hi = global_q;
        end
        on_lo = pwm_on(int_lo, step_q);
        on_hi = pwm_on(int_hi, step_q);
        seg_d = '0;
        cath_d = '1;
        if (slot_q[digit_q])
        begin
            seg_d = {lo_byte[7], ascii_glyph(lo_byte[6:0])} & {SEG_W{on_lo}};
            if (on_lo)
            begin
                cath_d[digit_q] = 1'b0;
            end
        end
        else
        begin
            seg_d[7:0] = seven_seg(lo_byte, decode_q[digit_q]) & {8{on_lo}};
            seg_d[15:8] = seven_seg(hi_byte, decode_q[digit_q]) & {8{on_hi}};
            if (on_lo || on_hi)
            begin
                cath_d[digit_q] = 1'b0;
            end
        end
        if (!cfg_q[CFG_SHDN])
        begin
            seg_d = '0;
            cath_d = '1;
        end
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cath_q <= '1;
            seg_q <= '0;
        end
        else
        begin
            cath_q <= cath_d;
            seg_q <= seg_d;
        end
    end

    // ------------------------------------------------------------------
    // port pins
    // ------------------------------------------------------------------
    // open drain: only ever pulls low, enable carries the data
    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gp_oe_q <= '0;
            gp_out_q <= '0;
        end
        else
        begin
            gp_oe_q <= ~pcfg_q & ~gdata_q;
            gp_out_q <= '0;
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    assign gp_rd = (pcfg_q & gp_lvl_q) | (~pcfg_q & gdata_q);

    always_comb
    begin
        rd_mux = 8'h00;
        case (reg_addr)
            ADDR_DECODE: rd_mux = decode_q;
            ADDR_GLOBAL: rd_mux = {4'h0, global_q};
            ADDR_SCAN: rd_mux = {5'h00, scan_q};
            ADDR_CFG:
            begin
                rd_mux = cfg_q & CFG_STORED_MASK;
                rd_mux[CFG_PHASE] = phase_q;
            end
            ADDR_GPIO_DATA: rd_mux = {3'h0, gp_rd};
            ADDR_PORT_CFG: rd_mux = {3'h0, pcfg_q};
            default:
            begin
                if (reg_addr[6:3] == ADDR_INTEN[6:3])
                begin
                    rd_mux = inten_q[reg_addr[2:0]];
                end
                else if (reg_addr[6:4] == ADDR_PLANE0[6:4])
                begin
                    rd_mux = plane0_q[reg_addr[3:0]];
                end
                else if (reg_addr[6:4] == ADDR_PLANE1[6:4])
                begin
                    rd_mux = plane1_q[reg_addr[3:0]];
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end
        else
        begin
            rvalid_q <= reg_rd_en;
            if (reg_rd_en)
            begin
                rdata_q <= rd_mux;
            end
        end
    end

    assign reg_rdata = rdata_q;
    assign reg_rvalid = rvalid_q;
    assign cathode_drive_outputs = cath_q;
    assign segment_drive = seg_q;
    assign multiplex_clock_buffered = osc_lvl_q;
    assign gpio_out = gp_out_q;
    assign gpio_oe = gp_oe_q;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence s_blink_restart;
        cfg_wr && reg_wdata[CFG_BRST];
    endsequence
    sequence s_clear_all;
        cfg_wr && reg_wdata[CFG_CLR];
    endsequence

    property p_slot_wo;
        reg_rd_en && reg_addr == ADDR_SLOT |=> reg_rvalid && reg_rdata == 8'h00;
    endproperty
    a_slot_wo: assert property (p_slot_wo) else $error("slot type read not zero");

    property p_cfg_read;
        reg_rd_en && reg_addr == ADDR_CFG |=> reg_rdata[CFG_BRST] == 1'b0
            && reg_rdata[CFG_CLR] == 1'b0 && reg_rdata[1] == 1'b0
            && reg_rdata[CFG_PHASE] == $past(phase_q);
    endproperty
    a_cfg_read: assert property (p_cfg_read) else $error("cfg readback wrong");

    property p_blink_restart;
        s_blink_restart |=> blink_cnt_q == 23'h0 && !phase_q;
    endproperty
    a_blink_restart: assert property (p_blink_restart) else $error("blink not restarted");

    property p_clear_all;
        s_clear_all |=> plane0_q[0] == 8'h00 && plane1_q[15] == 8'h00 ##1 !(cfg_q[CFG_CLR]);
    endproperty
    a_clear_all: assert property (p_clear_all) else $error("digit clear failed");

    property p_shutdown_dark;
        !cfg_q[CFG_SHDN] ##1 !cfg_q[CFG_SHDN] |-> cathode_drive_outputs == '1 && segment_drive == '0;
    endproperty
    a_shutdown_dark: assert property (p_shutdown_dark) else $error("lit in shutdown");

    property p_blank_step;
        step_q == 4'hF ##1 step_q == 4'hF |-> cathode_drive_outputs == '1;
    endproperty
    a_blank_step: assert property (p_blank_step) else $error("no interdigit blank");

    property p_scan_order;
        digit_adv |=> digit_q == (($past(digit_q) >= $past(scan_q)) ? 3'h0 : $past(digit_q) + 3'h1);
    endproperty
    a_scan_order: assert property (p_scan_order) else $error("scan order wrong");

    property p_plane0_only;
        !cfg_q[CFG_BLINK] |-> !plane_sel;
    endproperty
    a_plane0_only: assert property (p_plane0_only) else $error("second plane shown");

    property p_open_drain;
        gpio_oe[0] |-> gpio_out[0] == 1'b0 && $past(pcfg_q[0]) == 1'b0;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("port drives high");

endmodule

// ### common/ldm_pkg.sv
// constants shared by the multiplexed display controller
// assumes a single system clock; the multiplex clock arrives as a sampled pin
package ldm_pkg;

    // ------------------------------------------------------------------
    // register addresses (command byte bits 6..0)
    // ------------------------------------------------------------------
    localparam logic [6:0] ADDR_DECODE = 7'h01;
    localparam logic [6:0] ADDR_GLOBAL = 7'h02;
    localparam logic [6:0] ADDR_SCAN = 7'h03;
    localparam logic [6:0] ADDR_CFG = 7'h04;
    localparam logic [6:0] ADDR_GPIO_DATA = 7'h05;
    localparam logic [6:0] ADDR_PORT_CFG = 7'h06;
    localparam logic [6:0] ADDR_SLOT = 7'h0C;
    localparam logic [6:0] ADDR_INTEN = 7'h10;
    localparam logic [6:0] ADDR_PLANE0 = 7'h20;
    localparam logic [6:0] ADDR_PLANE1 = 7'h40;
    localparam logic [6:0] ADDR_BOTH = 7'h60;

    // ------------------------------------------------------------------
    // control_flags field positions and reset values
    // ------------------------------------------------------------------
    localparam int CFG_SHDN = 0;
    localparam int CFG_RATE = 2;
    localparam int CFG_BLINK = 3;
    localparam int CFG_BRST = 4;
    localparam int CFG_CLR = 5;
    localparam int CFG_IMODE = 6;
    localparam int CFG_PHASE = 7;
    localparam logic [7:0] CFG_STORED_MASK = 8'h4D;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [4:0] RST_PORT_CFG = 5'h1F;

    // ------------------------------------------------------------------
    // sizes and timing
    // ------------------------------------------------------------------
    localparam int NUM_DIGITS = 8;
    localparam int PLANE_DEPTH = 16;
    localparam int GPIO_W = 5;
    localparam int SEG_W = 17;
    localparam int OSC_FREQ_HZ = 4_000_000;
    localparam int DIGIT_TIME_US = 200;
    localparam int DIGIT_OSC_CYCLES = DIGIT_TIME_US * (OSC_FREQ_HZ / 1_000_000);
    localparam int PWM_STEPS = 16;
    localparam int STEP_OSC_CYCLES = DIGIT_OSC_CYCLES / PWM_STEPS;
    localparam logic [4:0] PWM_MAX_ON = 5'h0F;
    localparam int BLINK_SLOW_MHZ = 500;
    localparam int BLINK_FAST_MHZ = 1000;
    localparam int BLINK_SLOW_HALF = (OSC_FREQ_HZ / (2 * BLINK_SLOW_MHZ)) * 1000;
    localparam int BLINK_FAST_HALF = (OSC_FREQ_HZ / (2 * BLINK_FAST_MHZ)) * 1000;

    // ------------------------------------------------------------------
    // fonts: 7-segment hex (a=bit0..g=bit6), 16-segment ascii
    // ------------------------------------------------------------------
    localparam logic [6:0] ASCII_LO = 7'h28;
    localparam logic [6:0] HEX_CHARS = 7'h10;
    localparam logic [6:0] ASCII_OFS = 7'h18;
    localparam logic [6:0] HEX_FONT [16] = '{
        7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07,
        7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
    localparam logic [15:0] ASCII_FONT [104] = '{
        16'h00FF, 16'h000C, 16'h0377, 16'h033F, 16'h038C, 16'h03BB, 16'h03FB, 16'h000F,
        16'h03FF, 16'h03BF, 16'h03CF, 16'h4A3F, 16'h00F3, 16'h483F, 16'h01F3, 16'h01C3,
        16'h3000, 16'h8400, 16'hFF00, 16'h4B00, 16'h8000, 16'h0300, 16'h0000, 16'h9000,
        16'h00FF, 16'h000C, 16'h0377, 16'h033F, 16'h038C, 16'h03BB, 16'h03FB, 16'h000F,
        16'h03FF, 16'h03BF, 16'h4800, 16'h8800, 16'h3000, 16'h0330, 16'h8400, 16'h4207,
        16'h0AF7, 16'h03CF, 16'h4A3F, 16'h00F3, 16'h483F, 16'h01F3, 16'h01C3, 16'h02FB,
        16'h03CC, 16'h4833, 16'h007C, 16'h31C0, 16'h00F0, 16'h14CC, 16'h24CC, 16'h00FF,
        16'h03C7, 16'h20FF, 16'h23C7, 16'h03BB, 16'h4803, 16'h00FC, 16'h90C0, 16'hA0CC,
        16'hB400, 16'h5400, 16'h9033, 16'h00D1, 16'h2400, 16'h002E, 16'hA000, 16'h0030,
        16'h0400, 16'h03CF, 16'h4A3F, 16'h00F3, 16'h483F, 16'h01F3, 16'h01C3, 16'h02FB,
        16'h03CC, 16'h4833, 16'h007C, 16'h31C0, 16'h00F0, 16'h14CC, 16'h24CC, 16'h00FF,
        16'h03C7, 16'h20FF, 16'h23C7, 16'h03BB, 16'h4803, 16'h00FC, 16'h90C0, 16'hA0CC,
        16'hB400, 16'h5400, 16'h9033, 16'h4922, 16'h4800, 16'h4A11, 16'h0300, 16'hFFFF};

endpackage

// ### verif/ldm_host.sv
// host model: drives the parallel register access of the display controller
// assumes the bench calls wr and rd one at a time, inputs change at falling edge
`timescale 1ns/1ns
module ldm_host (
    input wire logic clock,
    output logic wr_en,
    output logic rd_en,
    output logic [6:0] addr,
    output logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic rvalid
);
    initial
    begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        addr = 7'h00;
        wdata = 8'h00;
    end
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge clock);
        wr_en = 1'b1;
        addr = a;
        wdata = d;
        @(negedge clock);
        wr_en = 1'b0;
        // released bus shows inverse, never the last value
        addr = ~a;
        wdata = ~d;
    endtask
    task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic ok);
        @(negedge clock);
        rd_en = 1'b1;
        addr = a;
        @(negedge clock);
        rd_en = 1'b0;
        addr = ~a;
        ok = rvalid;
        d = rdata;
    endtask
endmodule

// ### verif/led_display_mux_control_bench.sv
// bench: random and corner register traffic plus scan-order watch
// assumes ldm_host as bus master and short blink counts
`timescale 1ns/1ns
module led_display_mux_control_bench;
    import ldm_pkg::*;
    logic clock = 0, rst_n = 0, mux = 0, wr_en, rd_en, rvalid, ok;
    logic [6:0] addr;
    logic [7:0] wdata, rdata, v, rnd = 8'h25, cath, last;
    logic [16:0] seg;
    logic [16:0] es [3];
    logic [4:0] goe, gout;
    logic mbuf;
    logic [4:0] gin = 5'h00;
    int bad_count = 0, checked = 0, cyc = 0, n;
    initial forever #10 clock = ~clock;
    initial forever #100 mux = ~mux;
    ldm_host u_ldm_host (.clock(clock), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
        .wdata(wdata), .rdata(rdata), .rvalid(rvalid));
    ldm_display_ctrl #(.BLINK_SLOW_CYC(40), .BLINK_FAST_CYC(20)) u_ldm_display_ctrl (
        .clock(clock), .rst_n(rst_n), .multiplex_clock_in(mux),
        .multiplex_clock_buffered(mbuf), .reg_wr_en(wr_en), .reg_rd_en(rd_en),
        .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rvalid),
        .cathode_drive_outputs(cath), .segment_drive(seg), .gpio_in(gin),
        .gpio_out(gout), .gpio_oe(goe));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [7:0] sev(input logic [7:0] b, input logic d);
        return d ? {b[7], HEX_FONT[b[3:0]]} : b;
    endfunction
    // inputs read the pin, outputs read the stored data
    function automatic logic [7:0] port_rd(input logic [4:0] c, input logic [4:0] d,
        input logic [4:0] p);
        return {3'h0, (c & p) | (~c & d)};
    endfunction
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rchk(input logic [6:0] a, input logic [7:0] e);
        u_ldm_host.rd(a, v, ok);
        chk("rvalid", 8'h01, {7'h00, ok});
        chk("rdata", e, v);
    endtask
    task automatic chk_seg(input logic [16:0] e, input logic [16:0] g);
        checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("ERROR segment expected %h seen %h", e, g);
        end
    endtask
    task automatic conclude;
        $display("checked %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            bad_count++;
            conclude();
        end
    end
    initial
    begin
        repeat (4) @(posedge clock);
        @(negedge clock) rst_n = 1'b1;
        // five edges clear the three-flop filter whichever edge counts first
        @(posedge mux);
        repeat (5) @(negedge clock);
        chk("mux_buf", 8'h01, {7'h00, mbuf});
        @(negedge mux);
        repeat (5) @(negedge clock);
        chk("mux_buf", 8'h00, {7'h00, mbuf});
        rchk(ADDR_CFG, 8'h00);
        u_ldm_host.wr(ADDR_SLOT, 8'h55);
        rchk(ADDR_SLOT, 8'h00);
        u_ldm_host.wr(ADDR_BOTH, 8'h33);
        rchk(ADDR_BOTH, 8'h00);
        for (int i = 0; i < 6; i++)
        begin
            rnd = lfsr(rnd);
            gin = rnd[4:0];
            u_ldm_host.wr(ADDR_DECODE, rnd);
            rchk(ADDR_DECODE, rnd);
            u_ldm_host.wr(ADDR_PORT_CFG, {3'h0, rnd[7:3]});
            u_ldm_host.wr(ADDR_GPIO_DATA, {3'h0, rnd[5:1]});
            rchk(ADDR_GPIO_DATA, port_rd(rnd[7:3], rnd[5:1], rnd[4:0]));
            chk("gpio_oe", {3'h0, ~rnd[7:3] & ~rnd[5:1]}, {3'h0, goe});
            chk("gpio_out", 8'h00, {3'h0, gout});
        end
        // all ones: strobes and phase must not stick
        u_ldm_host.wr(ADDR_CFG, 8'hFF);
        rchk(ADDR_CFG, 8'h4D);
        n = 0;
        v = 8'h00;
        while (v[7] !== 1'b1 && n < 400)
        begin
            u_ldm_host.rd(ADDR_CFG, v, ok);
            n++;
        end
        chk("phase", 8'h01, {7'h00, v[7]});
        u_ldm_host.wr(ADDR_PLANE0, 8'h5A);
        rchk(ADDR_PLANE0, 8'h5A);
        // restart as well, so the phase bit reads back a known zero
        u_ldm_host.wr(ADDR_CFG, 8'h31);
        rchk(ADDR_PLANE0, 8'h00);
        rchk(ADDR_CFG, 8'h01);
        u_ldm_host.wr(ADDR_SCAN, 8'h02);
        u_ldm_host.wr(ADDR_PLANE0, 8'hC1);
        u_ldm_host.wr(ADDR_PLANE0 | 7'h01, 8'h8B);
        u_ldm_host.wr(ADDR_PLANE0 | 7'h09, 8'h26);
        es[0] = {1'b1, ASCII_FONT[7'h41 - ASCII_OFS]};
        es[1] = {1'b0, sev(8'h26, rnd[1]), sev(8'h8B, rnd[1])};
        es[2] = {1'b0, ASCII_FONT[0]};
        n = 0;
        while (cath !== 8'hFE && n < 40000)
        begin
            @(negedge clock);
            n++;
        end
        last = cath;
        for (int k = 1; k < 4; k++)
        begin
            n = 0;
            while ((cath === 8'hFF || cath === last) && n < 20000)
            begin
                @(negedge clock);
                n++;
            end
            last = cath;
            chk("cathode", ~(8'h01 << (k % 3)), cath);
            chk_seg(es[k % 3], seg);
        end
        conclude();
    end
endmodule
